// *** rtl/socket_supervisor_regs.vh ***
// constants for the programmer socket supervisor
// assumes a 125 MHz clk; included by bare name from the rtl files
`ifndef SOCKET_SUPERVISOR_REGS_VH
`define SOCKET_SUPERVISOR_REGS_VH
// alternation period in ms and the derived cycle count
`define ALT_PERIOD_MS 1500
`define CLK_KHZ 125000
`define ALT_CYCLES (`ALT_PERIOD_MS * `CLK_KHZ)
// error codes shown on the control unit
`define ERR_NONE 8'h00
`define ERR_E0 8'hE0
`define ERR_E4 8'hE4
`define ERR_E8 8'hE8
`define ERR_E9 8'hE9
`define ERR_EA 8'hEA
// supply level selects
`define VCC_OFF 2'h0
`define VCC_NOM 2'h1
`define VCC_HIGH 2'h2
`define VCC_LOW 2'h3
`define VPP_ZERO 2'h0
`define VPP_NOM 2'h1
`define VPP_HIGH 2'h2
`define VPP_LOW 2'h3
// functions requested by the control unit
`define FN_READ 3'h0
`define FN_PROGRAM 3'h1
`define FN_DUPLICATE 3'h2
`define FN_COMPARE 3'h3
`define FN_UPDATE 3'h4
`define FN_SELF_TEST 3'h5
// tone codes
`define TONE_NONE 2'h0
`define TONE_FAIL 2'h1
`define TONE_FAST 2'h2
`define TONE_SLOW 2'h3
// signature lookup table depth
`define SIG_TABLE_DEPTH 256
`endif

// *** rtl/signature_table.v ***
// lookup from an eight-bit signature byte to an algorithm code
// assumes the table is loaded by the host side; read data is registered
module signature_table #(
	parameter DATA_W = 8,
	parameter DEPTH = 256
) (
	input wire clk,
	input wire wr_en,
	input wire [7:0] wr_addr,
	input wire [DATA_W-1:0] wr_data,
	input wire [7:0] rd_addr,
	output reg [DATA_W-1:0] rd_data
);
	reg [DATA_W-1:0] mem [0:DEPTH-1];

	// no reset on the array; contents are defined by loading
	always @(posedge clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end
endmodule

// *** rtl/socket_supervisor.v ***
// supervisory sequencer for the programmer plug-in module
// assumes synchronous inputs on clk; analog supplies follow the level selects
`include "socket_supervisor_regs.vh"

// Notes on behaviour
// - two pending messages alternate on the display every 1.5 seconds.
// - socket supply stays off until a function starts and is removed when it ends.
// - after each programmed address, verify at high then low supply with compares.
// - programming supply never reaches the reference socket.
// - shorts on both socket supplies and target programming supply flag overload.
// - program or duplicate entry tests lines and reports E8 without overload on failure.
// - signature line drives to the raised level only, never high, to read and look up the signature.
// - overcurrent lights overload, removes programming supply and reports E8 with fail tone.
// - update reports E9 fast tone for bad code and EA slow tone for a failed write.
// - after reset report E4 for bad select or unseated module, E0 for bad source switches on a keypad unit.
// - busy lights whenever programming supply is applied and throughout duplication.
// - display shows the newly selected device type whenever the switches change.
// - self test steps supplies, address patterns, the programming waveform and short test.
module socket_supervisor #(
	parameter ALT_CYCLES = `ALT_CYCLES,
	parameter ADDR_W = 16
) (
	input wire clk,
	input wire resetn,
	input wire fn_start,
	input wire [2:0] fn_code,
	input wire keypad_unit,
	input wire [7:0] device_select,
	input wire select_valid,
	input wire module_seated,
	input wire source_switch_valid,
	input wire [ADDR_W-1:0] last_addr,
	input wire [7:0] source_data,
	input wire [7:0] target_data,
	input wire vcc_short_ref,
	input wire vcc_short_tgt,
	input wire vpp_short_tgt,
	input wire line_short,
	input wire sig_capable,
	input wire update_code_bad,
	input wire update_write_fail,
	input wire alg_wr_en,
	input wire [7:0] alg_wr_sig,
	input wire [7:0] alg_wr_code,
	output reg [1:0] tgt_vcc_sel,
	output reg ref_vcc_on,
	output reg [1:0] tgt_vpp_sel,
	output wire ref_vpp_on,
	output reg sig_line_high,
	output reg sig_line_raised,
	output reg [ADDR_W-1:0] tgt_addr,
	output reg prog_pulse,
	output reg overload_led,
	output reg busy_led,
	output reg fail_led,
	output reg [1:0] tone,
	output reg [7:0] err_code,
	output reg [7:0] disp_msg,
	output reg [7:0] alg_code,
	output reg fn_done,
	output reg fn_pass
);
	localparam S_IDLE = 4'h0;
	localparam S_LINES = 4'h1;
	localparam S_SIG = 4'h2;
	localparam S_SIG_RD = 4'h3;
	localparam S_PROG = 4'h4;
	localparam S_VHIGH = 4'h5;
	localparam S_VLOW = 4'h6;
	localparam S_END = 4'h7;
	localparam S_TEST = 4'h8;
	localparam S_FAULT = 4'h9;

	reg [3:0] state_r;
	reg [2:0] fn_r;
	reg [2:0] step_r;
	reg [7:0] sel_r;
	reg alt_pick_r;
	reg [31:0] alt_cnt_r;
	reg boot_r;
	wire [7:0] sig_alg;

	// vcc shorts always watched, vpp only while it is applied
	wire short_seen = vcc_short_ref | vcc_short_tgt |
		(vpp_short_tgt & (tgt_vpp_sel != `VPP_ZERO));
	assign ref_vpp_on = 1'b0;

	signature_table #(
		.DATA_W(8),
		.DEPTH(`SIG_TABLE_DEPTH)
	) u_sig (
		.clk(clk),
		.wr_en(alg_wr_en),
		.wr_addr(alg_wr_sig),
		.wr_data(alg_wr_code),
		.rd_addr(target_data),
		.rd_data(sig_alg)
	);

	// display alternation between device type and error message
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			alt_cnt_r <= 32'h0;
			alt_pick_r <= 1'b0;
			sel_r <= 8'h00;
			disp_msg <= 8'h00;
		end
		else
		begin
			sel_r <= device_select;
			if (err_code == `ERR_NONE || sel_r != device_select)
			begin
				alt_cnt_r <= 32'h0;
				alt_pick_r <= 1'b0;
			end
			else if (alt_cnt_r == ALT_CYCLES - 1)
			begin
				alt_cnt_r <= 32'h0;
				alt_pick_r <= ~alt_pick_r;
			end
			else
				alt_cnt_r <= alt_cnt_r + 32'h1;
			disp_msg <= alt_pick_r ? err_code : device_select;
		end
	end

	// main sequencer
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= S_IDLE;
			fn_r <= `FN_READ;
			step_r <= 3'h0;
			boot_r <= 1'b1;
			tgt_vcc_sel <= `VCC_OFF;
			ref_vcc_on <= 1'b0;
			tgt_vpp_sel <= `VPP_ZERO;
			sig_line_high <= 1'b0;
			sig_line_raised <= 1'b0;
			tgt_addr <= {ADDR_W{1'b0}};
			prog_pulse <= 1'b0;
			overload_led <= 1'b0;
			busy_led <= 1'b0;
			fail_led <= 1'b0;
			tone <= `TONE_NONE;
			err_code <= `ERR_NONE;
			alg_code <= 8'h00;
			fn_done <= 1'b0;
			fn_pass <= 1'b0;
		end
		else
		begin
			fn_done <= 1'b0;
			prog_pulse <= 1'b0;
			boot_r <= 1'b0;
			// power-on checks on the first cycle after release
			if (boot_r)
			begin
				if (!select_valid || !module_seated)
				begin
					err_code <= `ERR_E4;
					fail_led <= 1'b1;
				end
				else if (keypad_unit && !source_switch_valid)
				begin
					err_code <= `ERR_E0;
					fail_led <= 1'b1;
				end
			end
			// overcurrent overrides every state except idle and fault
			if (state_r != S_IDLE && state_r != S_FAULT && short_seen)
			begin
				overload_led <= 1'b1;
				tgt_vpp_sel <= `VPP_ZERO;
				tgt_vcc_sel <= `VCC_OFF;
				ref_vcc_on <= 1'b0;
				busy_led <= 1'b0;
				err_code <= `ERR_E8;
				fail_led <= 1'b1;
				tone <= `TONE_FAIL;
				state_r <= S_FAULT;
			end
			else
			begin
				case (state_r)
					S_IDLE:
					begin
						if (fn_start)
						begin
							// new function clears held faults
							overload_led <= 1'b0;
							fail_led <= 1'b0;
							tone <= `TONE_NONE;
							err_code <= `ERR_NONE;
							fn_r <= fn_code;
							tgt_addr <= {ADDR_W{1'b0}};
							step_r <= 3'h0;
							fn_pass <= 1'b0;
							if (fn_code == `FN_UPDATE)
								state_r <= S_END;
							else
							begin
								tgt_vcc_sel <= `VCC_NOM;
								ref_vcc_on <= (fn_code != `FN_SELF_TEST);
								busy_led <= (fn_code == `FN_DUPLICATE);
								if (fn_code == `FN_PROGRAM || fn_code == `FN_DUPLICATE)
									state_r <= S_LINES;
								else if (fn_code == `FN_SELF_TEST)
									state_r <= S_TEST;
								else
									state_r <= S_END;
							end
						end
					end
					S_LINES:
					begin
						if (line_short)
						begin
							err_code <= `ERR_E8;
							fail_led <= 1'b1;
							tone <= `TONE_FAIL;
							state_r <= S_FAULT;
						end
						else if (sig_capable)
						begin
							// raised level only: the logic-high drive must never meet it
							sig_line_high <= 1'b0;
							sig_line_raised <= 1'b1;
							state_r <= S_SIG;
						end
						else
						begin
							sig_line_high <= 1'b0;
							state_r <= S_PROG;
						end
					end
					S_SIG:
						state_r <= S_SIG_RD; // signature byte on target_data addresses the table
					S_SIG_RD:
					begin
						alg_code <= sig_alg;
						sig_line_raised <= 1'b0;
						sig_line_high <= 1'b0;
						state_r <= S_PROG;
					end
					S_PROG:
					begin
						tgt_vpp_sel <= `VPP_NOM;
						busy_led <= 1'b1;
						prog_pulse <= 1'b1;
						state_r <= S_VHIGH;
					end
					S_VHIGH:
					begin
						tgt_vpp_sel <= `VPP_ZERO;
						busy_led <= (fn_r == `FN_DUPLICATE);
						tgt_vcc_sel <= `VCC_HIGH;
						state_r <= S_VLOW;
					end
					S_VLOW:
					begin
						if (target_data != source_data)
							state_r <= S_FAULT;
						else if (tgt_vcc_sel == `VCC_HIGH)
							tgt_vcc_sel <= `VCC_LOW;
						else if (tgt_addr == last_addr)
						begin
							fn_pass <= 1'b1;
							state_r <= S_END;
						end
						else
						begin
							tgt_vcc_sel <= `VCC_NOM;
							tgt_addr <= tgt_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
							state_r <= S_PROG;
						end
						if (target_data != source_data)
						begin
							fail_led <= 1'b1;
							tone <= `TONE_FAIL;
						end
					end
					S_TEST:
					begin
						// one step per cycle through the test levels
						step_r <= step_r + 3'h1;
						case (step_r)
							3'h0: tgt_vcc_sel <= `VCC_HIGH;
							3'h1: tgt_vcc_sel <= `VCC_LOW;
							3'h2:
							begin
								// busy follows programming supply through the high and low steps
								tgt_vpp_sel <= `VPP_HIGH;
								busy_led <= 1'b1;
							end
							3'h3: tgt_vpp_sel <= `VPP_LOW;
							3'h4:
							begin
								tgt_vpp_sel <= `VPP_ZERO;
								busy_led <= 1'b0;
								tgt_addr <= ~tgt_addr;
							end
							3'h5:
							begin
								tgt_vpp_sel <= `VPP_NOM;
								prog_pulse <= 1'b1;
								busy_led <= 1'b1;
							end
							3'h6:
							begin
								tgt_vpp_sel <= `VPP_ZERO;
								busy_led <= 1'b0;
								tgt_vcc_sel <= `VCC_NOM;
							end
							default:
							begin
								if (line_short)
								begin
									err_code <= `ERR_E8;
									fail_led <= 1'b1;
									state_r <= S_FAULT;
								end
								else
								begin
									fn_pass <= 1'b1;
									state_r <= S_END;
								end
							end
						endcase
					end
					S_END:
					begin
						if (fn_r == `FN_UPDATE)
						begin
							fn_pass <= ~(update_code_bad | update_write_fail);
							if (update_code_bad)
							begin
								err_code <= `ERR_E9;
								tone <= `TONE_FAST;
								fail_led <= 1'b1;
							end
							else if (update_write_fail)
							begin
								err_code <= `ERR_EA;
								tone <= `TONE_SLOW;
								fail_led <= 1'b1;
							end
						end
						else if (fn_r != `FN_PROGRAM && fn_r != `FN_DUPLICATE
							&& fn_r != `FN_SELF_TEST)
							fn_pass <= 1'b1;
						tgt_vcc_sel <= `VCC_OFF;
						ref_vcc_on <= 1'b0;
						tgt_vpp_sel <= `VPP_ZERO;
						busy_led <= 1'b0;
						fn_done <= 1'b1;
						state_r <= S_IDLE;
					end
					S_FAULT:
					begin
						// faults stay lit until reset or next start
						tgt_vcc_sel <= `VCC_OFF;
						ref_vcc_on <= 1'b0;
						tgt_vpp_sel <= `VPP_ZERO;
						sig_line_high <= 1'b0;
						sig_line_raised <= 1'b0;
						busy_led <= 1'b0;
						fn_done <= 1'b1;
						fn_pass <= 1'b0;
						state_r <= S_IDLE;
					end
					default:
						state_r <= S_IDLE;
				endcase
			end
		end
	end
endmodule

// *** tb/supervisor_props.sv ***
// assertions on the socket supervisor ports
// assumes a bind to socket_supervisor, one clock, async low reset
`include "socket_supervisor_regs.vh"
module supervisor_props #(
	parameter ALT_CYCLES = 8,
	parameter ADDR_W = 16
) (
	input wire clk,
	input wire resetn,
	input wire fn_start,
	input wire fn_done,
	input wire vcc_short_ref,
	input wire vcc_short_tgt,
	input wire vpp_short_tgt,
	input wire [1:0] tgt_vcc_sel,
	input wire [1:0] tgt_vpp_sel,
	input wire ref_vpp_on,
	input wire sig_line_high,
	input wire sig_line_raised,
	input wire prog_pulse,
	input wire overload_led,
	input wire busy_led,
	input wire fail_led,
	input wire [1:0] tone,
	input wire [7:0] err_code,
	input wire [7:0] source_data,
	input wire [7:0] target_data
);
	wire short_any = vcc_short_ref | vcc_short_tgt | vpp_short_tgt;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_ref_vpp; !ref_vpp_on; endproperty
	a_ref_vpp: assert property (p_ref_vpp) else $error("vpp on reference");
	property p_busy; tgt_vpp_sel != `VPP_ZERO |-> busy_led; endproperty
	a_busy: assert property (p_busy) else $error("vpp without busy");
	property p_cold; fn_done |-> tgt_vcc_sel == `VCC_OFF ##1 !fn_done; endproperty
	a_cold: assert property (p_cold) else $error("supply on at end");
	property p_verify;
		prog_pulse && tgt_vcc_sel == `VCC_NOM && !short_any ##1
			!short_any && target_data == source_data |->
			tgt_vcc_sel == `VCC_HIGH ##1 tgt_vcc_sel == `VCC_LOW;
	endproperty
	a_verify: assert property (p_verify) else $error("verify steps wrong");
	property p_overload;
		busy_led && (vcc_short_ref || vcc_short_tgt ||
			(vpp_short_tgt && tgt_vpp_sel != `VPP_ZERO)) |=>
			overload_led && err_code == `ERR_E8 &&
			tgt_vpp_sel == `VPP_ZERO && fail_led && tone == `TONE_FAIL;
	endproperty
	a_overload: assert property (p_overload) else $error("overload missed");
	property p_hold; overload_led && !fn_start |=> overload_led; endproperty
	a_hold: assert property (p_hold) else $error("overload dropped");
	property p_sig; !(sig_line_high && sig_line_raised); endproperty
	a_sig: assert property (p_sig) else $error("line high and raised");
	property p_pulse; prog_pulse |-> busy_led && tgt_vpp_sel != `VPP_ZERO; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse without vpp");
endmodule
bind socket_supervisor supervisor_props #(.ALT_CYCLES(ALT_CYCLES), .ADDR_W(ADDR_W)) i_props (
	.clk, .resetn, .fn_start, .fn_done, .vcc_short_ref, .vcc_short_tgt, .vpp_short_tgt,
	.tgt_vcc_sel, .tgt_vpp_sel, .ref_vpp_on, .sig_line_high, .sig_line_raised,
	.prog_pulse, .overload_led, .busy_led, .fail_led, .tone, .err_code,
	.source_data, .target_data);

// *** tb/target_prom_model.sv ***
// behavioural part in the target socket
// assumes level selects from the supervisor; 256 bytes are modelled
module target_prom_model #(
	parameter logic [7:0] SIG_BYTE = 8'h3C // arbitrary signature value
) (
	input wire logic clk,
	input wire logic [1:0] vcc_sel,
	input wire logic [1:0] vpp_sel,
	input wire logic [15:0] addr,
	input wire logic prog,
	input wire logic sig_raised,
	input wire logic [7:0] din,
	output logic [7:0] dout
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:255];
	logic [7:0] last_r = 8'h00;
	initial foreach (mem[i]) mem[i] = 8'hFF;
	// programming only clears bits, and needs both supplies
	always @(posedge clk)
		if (prog && vpp_sel != 2'h0 && vcc_sel != 2'h0)
			mem[addr[7:0]] <= mem[addr[7:0]] & din;
	// an unpowered part floats, so the bus toggles rather than holding
	always_comb
		if (vcc_sel == 2'h0)
			dout = ~last_r;
		else if (sig_raised)
			dout = SIG_BYTE;
		else
			dout = mem[addr[7:0]];
	always @(posedge clk)
		last_r <= dout;
endmodule

// *** tb/tb.sv ***
// bench for the socket supervisor with a target part model
// assumes the regs header on the include path
`include "socket_supervisor_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, resetn = 0, fn_start = 0, keypad_unit = 1, select_valid = 0;
	logic module_seated = 1, source_switch_valid = 1, line_short = 0, sig_capable = 0;
	logic update_code_bad = 0, update_write_fail = 0, alg_wr_en = 0;
	logic [2:0] fn_code = 0, shorts = 0;
	logic [7:0] device_select = 8'h12, alg_wr_sig = 0, alg_wr_code = 0;
	logic [15:0] last_addr = 16'h0003, tgt_addr;
	logic [1:0] tgt_vcc_sel, tgt_vpp_sel, tone;
	logic ref_vcc_on, ref_vpp_on, sig_line_high, sig_line_raised, prog_pulse;
	logic overload_led, busy_led, fail_led, fn_done, fn_pass;
	logic [7:0] err_code, disp_msg, alg_code, target_data, source_data;
	int miscompares = 0, n_tests = 0, cycles = 0, n_alt;
	assign source_data = tgt_addr[7:0] ^ 8'h5A;
	socket_supervisor #(.ALT_CYCLES(8)) i_socket_supervisor (
		.clk, .resetn, .fn_start, .fn_code, .keypad_unit, .device_select, .select_valid,
		.module_seated, .source_switch_valid, .last_addr, .source_data, .target_data,
		.vcc_short_ref(shorts[0]), .vcc_short_tgt(shorts[1]), .vpp_short_tgt(shorts[2]),
		.line_short, .sig_capable, .update_code_bad, .update_write_fail, .alg_wr_en,
		.alg_wr_sig, .alg_wr_code, .tgt_vcc_sel, .ref_vcc_on, .tgt_vpp_sel, .ref_vpp_on,
		.sig_line_high, .sig_line_raised, .tgt_addr, .prog_pulse, .overload_led, .busy_led,
		.fail_led, .tone, .err_code, .disp_msg, .alg_code, .fn_done, .fn_pass);
	target_prom_model i_target_prom_model (.clk, .vcc_sel(tgt_vcc_sel),
		.vpp_sel(tgt_vpp_sel), .addr(tgt_addr), .prog(prog_pulse),
		.sig_raised(sig_line_raised), .din(source_data), .dout(target_data));
	always #4 clk = ~clk;
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// a hang counts as a mismatch and still reaches the verdict
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			close_out;
		end
	end
	task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
		n_tests++;
		if (s !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wait_cyc(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic do_reset;
		resetn = 0;
		wait_cyc(8);
		resetn = 1;
		wait_cyc(3);
	endtask
	// start a function, optionally inject a short partway, wait for done
	task automatic run(logic [2:0] c, logic [2:0] sh);
		int i;
		wait_cyc(1);
		fn_start = 1;
		fn_code = c;
		wait_cyc(1);
		fn_start = 0;
		for (i = 0; i < 2000 && fn_done !== 1'b1; i++)
		begin
			if (i == 10)
				shorts = sh;
			wait_cyc(1);
		end
		chk("fn_done", fn_done, 1);
	endtask
	initial
	begin
		do_reset;
		chk("e4 select", err_code, `ERR_E4);
		chk("fail", fail_led, 1);
		select_valid = 1;
		module_seated = 0;
		do_reset;
		chk("e4 seat", err_code, `ERR_E4);
		module_seated = 1;
		source_switch_valid = 0;
		do_reset;
		chk("e0", err_code, `ERR_E0);
		keypad_unit = 0;
		do_reset;
		chk("no error", err_code, `ERR_NONE);
		device_select = 8'h4C;
		wait_cyc(4);
		chk("display", disp_msg, 8'h4C);
		run(`FN_PROGRAM, 0);
		chk("pass", fn_pass, 1);
		chk("cold", tgt_vcc_sel, `VCC_OFF);
		chk("ref cold", ref_vcc_on, 0);
		chk("ref vpp", ref_vpp_on, 0);
		line_short = 1;
		run(`FN_DUPLICATE, 0);
		chk("line e8", err_code, `ERR_E8);
		chk("no overload", overload_led, 0);
		chk("line pass", fn_pass, 0);
		line_short = 0;
		run(`FN_DUPLICATE, 0);
		chk("dup pass", fn_pass, 1);
		chk("cleared", err_code, `ERR_NONE);
		last_addr = 16'h00FF;
		for (int k = 0; k < 3; k++)
		begin
			run(`FN_PROGRAM, 3'h1 << k);
			shorts = 0;
			chk("overload", overload_led, 1);
			chk("ovl e8", err_code, `ERR_E8);
			chk("vpp off", tgt_vpp_sel, `VPP_ZERO);
			n_alt = 0;
			repeat (32)
			begin
				wait_cyc(1);
				n_alt += (disp_msg === `ERR_E8);
			end
			chk("alternate", n_alt >= 8 && n_alt <= 24, 1);
			chk("held", overload_led, 1);
		end
		device_select = 8'h4D;
		wait_cyc(2);
		chk("display new", disp_msg, 8'h4D);
		run(`FN_READ, 0);
		chk("new start", overload_led, 0);
		for (int j = 0; j < 2; j++)
		begin
			update_code_bad = (j == 0);
			update_write_fail = (j == 1);
			run(`FN_UPDATE, 0);
			chk("upd err", err_code, j ? `ERR_EA : `ERR_E9);
			chk("upd tone", tone, j ? `TONE_SLOW : `TONE_FAST);
			chk("upd fail", fail_led, 1);
		end
		update_write_fail = 0;
		alg_wr_en = 1;
		alg_wr_sig = 8'h3C;
		alg_wr_code = 8'h07;
		wait_cyc(1);
		alg_wr_en = 0;
		sig_capable = 1;
		last_addr = 16'h0000;
		run(`FN_PROGRAM, 0);
		chk("algorithm", alg_code, 8'h07);
		chk("sig released", sig_line_raised, 0);
		chk("sig high off", sig_line_high, 0);
		sig_capable = 0;
		run(`FN_COMPARE, 0);
		chk("cmp pass", fn_pass, 1);
		run(`FN_SELF_TEST, 0);
		chk("self test", fn_pass, 1);
		chk("st cold", tgt_vcc_sel, `VCC_OFF);
		close_out;
	end
endmodule
